// ### test_wdrc_top.sv
/*
  Self-checking bench for the runaway timer and reset-pin controller.
  Assumes short timer periods (exponents 4..7) and the external model beside the design.
*/
module test_wdrc_top;
  import wdrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, resetn, cmdEnable, cmdDisable, cmdClear;
  logic [1:0] watchdogModeReg, powerMode;
  logic       resetOutOnBoot, faultToResetPin, supplyOkPin, resetPinIn, intPinIn;
  logic       resetPinOut, resetPinOe, watchdogFaultPinOut, watchdogFaultPinOe;
  logic       resetAccepted, stopWake, timerEnabled;
  int         err_count = 0;
  int         comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////
  // design and far side
  wdrc_top #(.PERIOD_EXP_BASE(4), .PERIOD_EXP_STEP(1)) wdrc_top_inst (
    .ref_clk(ref_clk), .resetn(resetn), .cmdEnable(cmdEnable), .cmdDisable(cmdDisable),
    .cmdClear(cmdClear), .watchdogModeReg(watchdogModeReg), .powerMode(powerMode),
    .resetOutOnBoot(resetOutOnBoot), .faultToResetPin(faultToResetPin), .supplyOkPin(supplyOkPin),
    .resetPinIn(resetPinIn), .intPinIn(intPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .watchdogFaultPinOut(watchdogFaultPinOut), .watchdogFaultPinOe(watchdogFaultPinOe),
    .resetAccepted(resetAccepted), .stopWake(stopWake), .timerEnabled(timerEnabled));
  wdrc_ext_model wdrc_ext_model_inst (.ref_clk(ref_clk), .resetPinOe(resetPinOe),
    .resetPinIn(resetPinIn), .intPinIn(intPinIn));
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers; outputs are sampled at the falling edge, away from updates
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return watchdogFaultPinOe;
      1: return resetPinOe;
      2: return resetAccepted;
      default: return stopWake;
    endcase
  endfunction
  // n is the lim value when the output never rose
  task automatic wait_hi(input int s, input int lim, output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pick(s) !== 1'b1 && n < lim);
  endtask
  task automatic len_hi(input int s, output int n);
    n = 0;
    while (pick(s) === 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic cmd(input logic e, input logic d, input logic c);
    @(posedge ref_clk);
    cmdEnable <= e;
    cmdDisable <= d;
    cmdClear <= c;
    @(posedge ref_clk);
    {cmdEnable, cmdDisable, cmdClear} <= 3'h0;
  endtask
  // first clear drops any held fault, second one starts the measured count
  task automatic restart();
    cmd(1'b0, 1'b0, 1'b1);
    cmd(1'b0, 1'b0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_powerup();
    int n;
    chk(timerEnabled === 1'b1, "timer off after reset");
    @(posedge ref_clk);
    supplyOkPin <= 1'b1;
    wait_hi(1, 20, n);
    chk(resetPinOut === 1'b0 && watchdogFaultPinOut === 1'b0, "open-drain level not low");
    len_hi(1, n);
    chk(n == POR_CYC && n >= POR_MIN_US * CLK_PER_US && n <= POR_MAX_US * CLK_PER_US, "power-up drive");
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic t_timeout();
    int n;
    for (int e = 0; e < 4; e++) begin
      @(posedge ref_clk);
      watchdogModeReg <= 2'(e);
      restart();
      wait_hi(0, 300, n);
      chk(n >= (1 << (4 + e)) && n <= (1 << (4 + e)) + 1, "timeout period");
    end
    repeat (50) @(negedge ref_clk);
    chk(watchdogFaultPinOe === 1'b1, "held fault dropped");
    cmd(1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge ref_clk);
    chk(watchdogFaultPinOe === 1'b0, "clear kept fault");
  endtask
  task automatic t_pulse();
    int n;
    @(posedge ref_clk);
    faultToResetPin <= 1'b1;
    watchdogModeReg <= 2'h0;
    restart();
    // clear lands on the very edge the count hits its limit: the timeout must still win
    repeat (14) @(posedge ref_clk);
    cmd(1'b0, 1'b0, 1'b1);
    wait_hi(0, 100, n);
    chk(n == 1, "clear hid a timeout");
    len_hi(0, n);
    chk(n == FAULT_CYC, "fault pulse width");
    @(posedge ref_clk);
    faultToResetPin <= 1'b0;
  endtask
  // frozen count in power-down, wake filter, then counting again in idle
  task automatic t_powerdown();
    int n;
    @(posedge ref_clk);
    powerMode <= 2'h2;
    restart();
    wait_hi(0, 60, n);
    chk(n == 60, "count ran in power-down");
    wdrc_ext_model_inst.hold_int(10);
    wait_hi(3, 20, n);
    chk(n == 20, "short wake taken");
    wdrc_ext_model_inst.hold_int(WAKE_LOW_CYC);
    wait_hi(3, 25, n);
    chk(n < 25, "wake missed");
    @(posedge ref_clk);
    powerMode <= 2'h1;
    wait_hi(0, 30, n);
    chk(n >= 15 && n <= 19, "idle did not count");
    @(posedge ref_clk);
    powerMode <= 2'h0;
  endtask
  task automatic t_reset();
    int n;
    cmd(1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge ref_clk);
    chk(timerEnabled === 1'b0, "disable lost");
    wait_hi(0, 100, n);
    chk(n == 100, "fault while off");
    cmd(1'b1, 1'b0, 1'b0);
    repeat (2) @(negedge ref_clk);
    chk(timerEnabled === 1'b1, "enable lost");
    cmd(1'b0, 1'b1, 1'b0);
    wdrc_ext_model_inst.hold_reset(2);
    wait_hi(2, 12, n);
    chk(n == 12, "short reset taken");
    wdrc_ext_model_inst.hold_reset(RST_ACCEPT_CYC);
    wait_hi(2, 12, n);
    chk(n < 12 && resetPinOe === 1'b0, "reset handling");
    repeat (2) @(negedge ref_clk);
    chk(timerEnabled === 1'b1, "not enabled by reset");
    @(posedge ref_clk);
    resetOutOnBoot <= 1'b1;
    wdrc_ext_model_inst.hold_reset(4);
    wait_hi(1, 20, n);
    len_hi(1, n);
    chk(n == RST_PULSE_CYC, "boot reset pulse");
    @(posedge ref_clk);
    resetOutOnBoot <= 1'b0;
  endtask
  // reset in mid-run with the supply still good: enabled timer and a fresh power-up drive
  task automatic t_rereset();
    int n;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk(timerEnabled === 1'b1 && resetPinOe === 1'b0, "state after reset");
    wait_hi(1, 20, n);
    len_hi(1, n);
    chk(n == POR_CYC, "second power-up drive");
    repeat (8) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict, clock, watchdog and main sequence
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // whole run is near 3100 cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("ERROR %0t run did not finish", $time);
    tally_and_finish();
  end
  initial begin
    {resetn, cmdEnable, cmdDisable, cmdClear} = 4'h0;
    {watchdogModeReg, powerMode} = 4'h0;
    {resetOutOnBoot, faultToResetPin, supplyOkPin} = 3'h0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    t_powerup();
    t_timeout();
    t_pulse();
    t_powerdown();
    t_reset();
    t_rereset();
    tally_and_finish();
  end
endmodule

// ### wdrc_ext_model.sv
/*
  Model of the circuitry outside the controller: pulled-up reset and interrupt lines.
  Assumes its tasks are called from one process that runs on ref_clk.
*/
module wdrc_ext_model (
  input  wire logic ref_clk,
  input  wire logic resetPinOe,
  output logic      resetPinIn,
  output logic      intPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rstLow = 1'b0;
  logic intLow = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // wired lines: pull-up wins unless some party pulls low
  assign resetPinIn = ~(resetPinOe | rstLow);
  assign intPinIn   = ~intLow;
  ////////////////////////////////////////////////////////////////////////////
  // reset push held for whole clocks, so the device sees a clean width
  task automatic hold_reset(input int n);
    @(posedge ref_clk);
    rstLow <= 1'b1;
    repeat (n) @(posedge ref_clk);
    rstLow <= 1'b0;
  endtask
  // interrupt line held low to leave the stopped state
  task automatic hold_int(input int n);
    @(posedge ref_clk);
    intLow <= 1'b1;
    repeat (n) @(posedge ref_clk);
    intLow <= 1'b0;
  endtask
endmodule

// ### wdrc_pkg.sv
/*
  Shared constants, state encodings and timing counts for the watchdog and reset-pin controller.
  Assumes a single 20 MHz system clock; all times but the power-up window limits are turned into cycle counts here.
*/
package wdrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and times
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
  localparam int POR_MIN_US    = 25;
  localparam int POR_MAX_US    = 75;
  localparam int POR_DRIVE_US  = 50;  // middle of the allowed window, margin both ways
  localparam int POR_CYC       = POR_DRIVE_US * CLK_PER_US;
  localparam int FAULT_PULSE_NS = 20_000;
  localparam int FAULT_CYC     = (FAULT_PULSE_NS * CLK_PER_US) / 1000;
  localparam int RST_PULSE_CYC = 15;
  localparam int RST_ACCEPT_CYC = 3;
  localparam int WAKE_LOW_CYC  = 15;
  localparam int GUARD_CYC     = 4;  // covers synchroniser delay of our own pin drive

  ////////////////////////////////////////////////////////////////////////////
  // widths and power modes
  localparam int PCNT_W = 11;
  localparam int FCNT_W = 9;
  localparam int TMR_W  = 23;
  localparam logic [1:0] PWR_RUN  = 2'h0;
  localparam logic [1:0] PWR_IDLE = 2'h1;

  typedef enum logic [4:0] {
    ST_POWERUP  = 5'h01,
    ST_PORDRIVE = 5'h02,
    ST_GUARD    = 5'h04,
    ST_RUN      = 5'h08,
    ST_RSTDRIVE = 5'h10
  } wdrc_state_t;

endpackage

// ### wdrc_sync.sv
/*
  Three-stage synchroniser for pin inputs with agreement filter.
  Assumes inputs are asynchronous to clk; output changes once stages two and three agree.
*/
module wdrc_sync #(
  parameter int          WIDTH = 3,
  parameter logic [31:0] INIT  = 32'hFFFF_FFFF
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] stable_r;

  ////////////////////////////////////////////////////////////////////////////
  // stage1 is read only by stage2, never by the filter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1_r <= INIT[WIDTH-1:0];
      stage2_r <= INIT[WIDTH-1:0];
      stage3_r <= INIT[WIDTH-1:0];
      stable_r <= INIT[WIDTH-1:0];
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          stable_r[i] <= stage3_r[i];
        end
      end
    end
  end

  assign pinOut = stable_r;

endmodule

// ### wdrc_top.sv
/*
  Runaway timer with fault output and bidirectional reset-pin control.
  Assumes software commands arrive as one-cycle pulses from logic on ref_clk, and that the
  pins (reset, interrupt, supply detector) are asynchronous and synchronised here.
*/
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int PERIOD_EXP_BASE = 16, // exponent of the shortest period
  parameter int PERIOD_EXP_STEP = 2   // exponent added per select step
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       cmdEnable,
  input  wire logic       cmdDisable,
  input  wire logic       cmdClear,
  input  wire logic [1:0] watchdogModeReg,
  input  wire logic [1:0] powerMode,
  input  wire logic       resetOutOnBoot,
  input  wire logic       faultToResetPin,
  input  wire logic       supplyOkPin,
  input  wire logic       resetPinIn,
  input  wire logic       intPinIn,
  output logic            resetPinOut,
  output logic            resetPinOe,
  output logic            watchdogFaultPinOut,
  output logic            watchdogFaultPinOe,
  output logic            resetAccepted,
  output logic            stopWake,
  output logic            timerEnabled
);

  typedef struct packed {
    wdrc_state_t       state;
    logic [PCNT_W-1:0] pulseCnt;
    logic [1:0]        lowCnt;
    logic              lowSeen;
    logic              pinOe;
    logic              accepted;
    logic              wdEn;
    logic [TMR_W-1:0]  runawayTimer;
    logic              faultLow;
    logic [FCNT_W-1:0] faultCnt;
    logic [3:0]        intCnt;
    logic              wake;
  } wdrc_regs_t;

  wdrc_regs_t st_r;
  wdrc_regs_t st_nxt;
  logic [2:0] syncOut;
  logic       rstPinS;
  logic       supplyS;
  logic       intPinS;
  logic       counting;
  logic       timeoutNow;

  // period limit decode, shared by the timer and its check
  function automatic logic [TMR_W-1:0] periodLimit(input logic [1:0] sel);
    int e;
    e           = PERIOD_EXP_BASE + PERIOD_EXP_STEP * int'(sel);
    periodLimit = TMR_W'((64'h1 << e) - 64'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: reset pin, supply detector, interrupt line
  wdrc_sync #(
    .WIDTH (3),
    .INIT  (32'h0000_0005)
  ) u_sync (
    .clk    (ref_clk),
    .resetn (resetn),
    .pinIn  ({intPinIn, supplyOkPin, resetPinIn}),
    .pinOut (syncOut)
  );
  assign rstPinS = syncOut[0];
  assign supplyS = syncOut[1];
  assign intPinS = syncOut[2];

  // timer counts only in run or idle; other power-down modes freeze it
  assign counting = st_r.wdEn && !st_r.faultLow && (powerMode == PWR_RUN || powerMode == PWR_IDLE);
  // at or past the limit: a period shortened under a running count must not wrap the timer
  assign timeoutNow = counting && (st_r.runawayTimer >= periodLimit(watchdogModeReg));

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_nxt          = st_r;
    st_nxt.accepted = 1'b0;
    st_nxt.wake     = 1'b0;

    // reset pin sequencing
    case (st_r.state)
      ST_POWERUP: begin
        st_nxt.pinOe = 1'b0;
        if (supplyS) begin
          st_nxt.state    = ST_PORDRIVE;
          st_nxt.pinOe    = 1'b1;
          st_nxt.pulseCnt = '0;
        end
      end
      ST_PORDRIVE: begin
        st_nxt.pulseCnt = st_r.pulseCnt + PCNT_W'(1);
        if (st_r.pulseCnt == PCNT_W'(POR_CYC - 1)) begin
          st_nxt.pinOe    = 1'b0;
          st_nxt.state    = ST_GUARD;
          st_nxt.pulseCnt = '0;
        end
      end
      ST_GUARD: begin
        // own drive is still echoing through the synchroniser
        st_nxt.pulseCnt = st_r.pulseCnt + PCNT_W'(1);
        st_nxt.lowCnt   = '0;
        st_nxt.lowSeen  = 1'b0;
        if (st_r.pulseCnt == PCNT_W'(GUARD_CYC - 1)) begin
          st_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rstPinS) begin
          st_nxt.lowCnt  = '0;
          st_nxt.lowSeen = 1'b0;
        end else if (!st_r.lowSeen) begin
          st_nxt.lowCnt = st_r.lowCnt + 2'h1;
          if (st_r.lowCnt == 2'(RST_ACCEPT_CYC - 1)) begin
            st_nxt.accepted = 1'b1;
            st_nxt.lowSeen  = 1'b1;
            if (resetOutOnBoot) begin
              st_nxt.state    = ST_RSTDRIVE;
              st_nxt.pinOe    = 1'b1;
              st_nxt.pulseCnt = '0;
            end
          end
        end
      end
      ST_RSTDRIVE: begin
        st_nxt.pulseCnt = st_r.pulseCnt + PCNT_W'(1);
        if (st_r.pulseCnt == PCNT_W'(RST_PULSE_CYC - 1)) begin
          st_nxt.pinOe    = 1'b0;
          st_nxt.state    = ST_GUARD;
          st_nxt.pulseCnt = '0;
        end
      end
      default: begin
        st_nxt.state = ST_POWERUP;
        st_nxt.pinOe = 1'b0;
      end
    endcase

    // runaway timer; an accepted reset restarts it enabled unless cmdDisable arrives in the same cycle
    if (cmdEnable) begin
      st_nxt.wdEn = 1'b1;
    end
    if (cmdDisable) begin
      st_nxt.wdEn         = 1'b0;
      st_nxt.faultLow     = 1'b0;
      st_nxt.runawayTimer = '0;
    end else if (cmdClear || st_nxt.accepted) begin
      // a timeout landing with the clear still raises the fault: set wins
      st_nxt.runawayTimer = '0;
      st_nxt.faultLow     = timeoutNow && !st_nxt.accepted;
      st_nxt.faultCnt     = '0;
      if (st_nxt.accepted) begin
        st_nxt.wdEn = 1'b1;
      end
    end else if (st_r.faultLow) begin
      // elsewhere-wired output just holds; reset-wired one times out
      if (faultToResetPin) begin
        st_nxt.faultCnt = st_r.faultCnt + FCNT_W'(1);
        if (st_r.faultCnt == FCNT_W'(FAULT_CYC - 1)) begin
          st_nxt.faultLow     = 1'b0;
          st_nxt.runawayTimer = '0;
        end
      end
    end else if (counting) begin
      if (timeoutNow) begin
        st_nxt.faultLow = 1'b1;
        st_nxt.faultCnt = '0;
      end else begin
        st_nxt.runawayTimer = st_r.runawayTimer + TMR_W'(1);
      end
    end

    // wake from stop: interrupt line low for the full count
    if (intPinS || powerMode == PWR_RUN || powerMode == PWR_IDLE) begin
      st_nxt.intCnt = '0;
    end else if (st_r.intCnt != 4'(WAKE_LOW_CYC)) begin
      st_nxt.intCnt = st_r.intCnt + 4'h1;
      if (st_r.intCnt == 4'(WAKE_LOW_CYC - 1)) begin
        st_nxt.wake = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; timer enabled straight out of reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r       <= '0;
      st_r.state <= ST_POWERUP;
      st_r.wdEn  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // open-drain pins only ever drive low
  assign resetPinOut         = 1'b0;
  assign resetPinOe          = st_r.pinOe;
  assign watchdogFaultPinOut = 1'b0;
  assign watchdogFaultPinOe  = st_r.faultLow;
  assign resetAccepted       = st_r.accepted;
  assign stopWake            = st_r.wake;
  assign timerEnabled        = st_r.wdEn;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int A_POR_HI   = POR_CYC;
  localparam int A_FAULT_HI = FAULT_CYC;

  a_por_enabled: assert property (@(posedge ref_clk) !resetn ##1 resetn |-> timerEnabled)
    else $error("timer not enabled after reset");
  a_halt_powerdown: assert property (@(posedge ref_clk) disable iff (!resetn)
    (powerMode[1] && !cmdClear && !cmdDisable && !st_nxt.accepted) |=> $stable(st_r.runawayTimer))
    else $error("timer moved in power-down");
  a_fault_timeout: assert property (@(posedge ref_clk) disable iff (!resetn)
    (counting && st_r.runawayTimer == periodLimit(watchdogModeReg) && !cmdDisable
     && !st_nxt.accepted) |=> watchdogFaultPinOe)
    else $error("fault not raised at period end");
  a_reset_accept: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetAccepted) |-> $past(st_r.state == ST_RUN) && !$past(rstPinS, 1) && !$past(rstPinS, 2)
    && !$past(rstPinS, 3))
    else $error("reset accepted before three low cycles");
  a_por_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($rose(resetPinOe) && st_r.state == ST_PORDRIVE) |-> resetPinOe[*8] ##[1:A_POR_HI] !resetPinOe)
    else $error("power-up drive length wrong");
  a_rst_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($rose(resetPinOe) && st_r.state == ST_RSTDRIVE) |-> ##15 !resetPinOe)
    else $error("reset pulse not 15 cycles");
  a_fault_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($rose(watchdogFaultPinOe) && faultToResetPin) |-> ##[1:A_FAULT_HI] !watchdogFaultPinOe)
    else $error("fault pulse too long");
  a_fault_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (watchdogFaultPinOe && !faultToResetPin && !cmdClear && !cmdDisable && !st_nxt.accepted)
    |=> watchdogFaultPinOe)
    else $error("held fault released without clear");
  a_clear_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmdClear && !cmdDisable) |=> (watchdogFaultPinOe == $past(timeoutNow && !st_nxt.accepted))
    && st_r.runawayTimer == '0)
    else $error("clear did not restart timer");

endmodule
